// File: logic/crcpe_pkg.sv
// Constants for the configurable CRC engine
package crcpe_pkg;
	// Widths
	localparam int ACC_W = 16;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 3;
	localparam int LEN_W = 4;
	localparam int CNT_W = 5;
	localparam int FIFO_DEPTH = 16;

	// Register offsets
	localparam logic [2:0] OFS_CTRL = 3'h0;
	localparam logic [2:0] OFS_LEN = 3'h1;
	localparam logic [2:0] OFS_ACC_LOW = 3'h2;
	localparam logic [2:0] OFS_ACC_HIGH = 3'h3;
	localparam logic [2:0] OFS_TAPS_LOW = 3'h4;
	localparam logic [2:0] OFS_TAPS_HIGH = 3'h5;
	localparam logic [2:0] OFS_DATA_LOW = 3'h6;
	localparam logic [2:0] OFS_DATA_HIGH = 3'h7;

	// Control register bit positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_GO_BIT = 1;
	localparam int CTRL_ORDER_BIT = 2;
	localparam int CTRL_AUG_BIT = 3;
	localparam int CTRL_BUSY_BIT = 6;
	localparam int CTRL_FULL_BIT = 7;

	// Length register field positions
	localparam int WLEN_LSB = 0;
	localparam int POLY_LEN_LSB = 4;

	// Reset values
	localparam logic [3:0] WLEN_RST = 4'h0;
	localparam logic [3:0] POLY_LEN_RST = 4'h0;
	localparam logic [15:0] ACC_RST = 16'h0000;
	localparam logic [15:0] TAPS_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// Engine states, Gray along idle, data, augment
	typedef enum logic [1:0] {
		CRCPE_IDLE = 2'b00,
		CRCPE_DATA = 2'b01,
		CRCPE_AUG = 2'b11
	} crcpe_state_t;
endpackage

// File: logic/crcpe_engine.sv
// CRC engine with register port, word FIFO and bit-serial shift register
//
// Functional notes
// - Accumulator n bits up to 16; length field holds n minus one.
// - Top and bottom polynomial coefficients always treated as one.
// - Intermediate coefficients come from a 16-bit taps register.
// - Taps bit 0 has no storage, calculation uses one there.
// - Software may seed the accumulator with any 16-bit start remainder.
// - Division by XOR feedback shift register; result readable in accumulator.
// - Standard or reversed bit order; reversed feeds word bits mirrored.
// - Automatic augmentation zeros, or software feeds zeros as plain data.
// - Words arrive from the memory scanner or from software data writes.
// - Only word-length low data bits are used, the rest ignored.
// - Order clear shifts MSb first; order set shifts LSb first.
// - Augment set feeds data straight into the feedback, no zeros appended; clear also stops after data.
// - Low data byte write latches both bytes; write high byte first.
`timescale 1ns/100ps

// Synchronous word FIFO with valid and ready on both sides
module crcpe_fifo #(
	parameter int WIDTH = crcpe_pkg::ACC_W,
	parameter int DEPTH = crcpe_pkg::FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTR_W = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
		$error("FIFO depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0] count_reg;
	logic push;
	logic pop;

	// Handshakes from the fill level
	assign in_ready = (count_reg != DEPTH[PTR_W:0]);
	assign out_valid = (count_reg != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_ptr_reg];

	// Storage write
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

// Top: register port, scanner port, FIFO and shift engine
module crcpe_engine #(
	parameter int FIFO_D = crcpe_pkg::FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [crcpe_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [crcpe_pkg::BYTE_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [crcpe_pkg::BYTE_W-1:0] reg_rdata,
	input wire logic scan_valid,
	input wire logic [crcpe_pkg::ACC_W-1:0] scan_data,
	output logic scan_ready,
	output logic busy,
	output logic full
);
	if (FIFO_D < 2) begin : g_bad_fifo
		$error("FIFO_D must be at least 2");
	end

	logic en_reg;
	logic go_reg;
	logic order_reg;
	logic aug_reg;
	logic [3:0] word_len_reg;
	logic [3:0] poly_len_reg;
	logic [15:0] acc_reg;
	logic [15:1] taps_reg;
	logic [7:0] data_high_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [15:0] word_reg;
	logic [4:0] cnt_reg;
	crcpe_pkg::crcpe_state_t state_reg;
	logic sw_push;
	logic run;
	logic f_in_valid;
	logic f_in_ready;
	logic [15:0] f_in_data;
	logic f_out_valid;
	logic [15:0] f_out_data;
	logic pop;
	logic acc_wr;
	logic [3:0] bit_idx;
	logic last_bit;
	logic [15:0] poly;

	// One shift of the feedback register; augmenting feeds data straight into the feedback,
	// same as zeros after the last word, where zeros after every word spoil multi-word sums
	function automatic logic [15:0] crc_step(input logic [15:0] acc, input logic din,
			input logic [15:0] taps, input logic [3:0] poly_len, input logic direct);
		logic [15:0] mask;
		logic fb;
		logic [15:0] nxt;
		mask = 16'hFFFF >> (4'hF - poly_len);
		fb = direct ? (acc[poly_len] ^ din) : acc[poly_len];
		nxt = ((acc << 1) | {15'h0000, din && !direct}) & mask;
		if (fb) begin
			nxt = nxt ^ (taps & mask);
		end
		return nxt;
	endfunction

	// Decoded strobes
	assign sw_push = reg_wr && (reg_addr == crcpe_pkg::OFS_DATA_LOW);
	assign acc_wr = reg_wr && ((reg_addr == crcpe_pkg::OFS_ACC_LOW) ||
		(reg_addr == crcpe_pkg::OFS_ACC_HIGH));
	assign run = en_reg && go_reg;
	assign poly = {taps_reg, 1'b1};

	// Source select: software write beats the scanner in a shared cycle
	assign f_in_valid = sw_push || (scan_valid && run);
	assign f_in_data = sw_push ? {data_high_reg, reg_wdata} : scan_data;
	assign scan_ready = f_in_ready && !sw_push && run;
	assign full = !f_in_ready;

	crcpe_fifo #(
		.WIDTH(crcpe_pkg::ACC_W),
		.DEPTH(FIFO_D)
	) u_fifo (
		.ref_clk(ref_clk),
		.srst(srst),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(f_in_data),
		.out_valid(f_out_valid),
		.out_ready(pop),
		.out_data(f_out_data)
	);

	// Engine takes a word only when idle and running
	assign pop = (state_reg == crcpe_pkg::CRCPE_IDLE) && f_out_valid && run;
	assign busy = (state_reg != crcpe_pkg::CRCPE_IDLE) || f_out_valid;

	// Bit selection by order; index top is the word length
	assign bit_idx = order_reg ? cnt_reg[3:0] : (word_len_reg - cnt_reg[3:0]);
	assign last_bit = (cnt_reg[3:0] == word_len_reg);

	// Control register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			en_reg <= 1'b0;
			go_reg <= 1'b0;
			order_reg <= 1'b0;
			aug_reg <= 1'b0;
		end else if (reg_wr && reg_addr == crcpe_pkg::OFS_CTRL) begin
			en_reg <= reg_wdata[crcpe_pkg::CTRL_EN_BIT];
			go_reg <= reg_wdata[crcpe_pkg::CTRL_GO_BIT] && reg_wdata[crcpe_pkg::CTRL_EN_BIT];
			order_reg <= reg_wdata[crcpe_pkg::CTRL_ORDER_BIT];
			aug_reg <= reg_wdata[crcpe_pkg::CTRL_AUG_BIT];
		end
	end

	// Length fields, each length minus one
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			word_len_reg <= crcpe_pkg::WLEN_RST;
			poly_len_reg <= crcpe_pkg::POLY_LEN_RST;
		end else if (reg_wr && reg_addr == crcpe_pkg::OFS_LEN) begin
			word_len_reg <= reg_wdata[crcpe_pkg::WLEN_LSB +: 4];
			poly_len_reg <= reg_wdata[crcpe_pkg::POLY_LEN_LSB +: 4];
		end
	end

	// Taps, bit 0 has no storage
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			taps_reg <= crcpe_pkg::TAPS_RST[15:1];
		end else if (reg_wr && reg_addr == crcpe_pkg::OFS_TAPS_LOW) begin
			taps_reg[7:1] <= reg_wdata[7:1];
		end else if (reg_wr && reg_addr == crcpe_pkg::OFS_TAPS_HIGH) begin
			taps_reg[15:8] <= reg_wdata;
		end
	end

	// High data byte waits for the low byte write
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			data_high_reg <= crcpe_pkg::BYTE_RST;
		end else if (reg_wr && reg_addr == crcpe_pkg::OFS_DATA_HIGH) begin
			data_high_reg <= reg_wdata;
		end
	end

	// Accumulator: seed write wins over a shift in the same cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			acc_reg <= crcpe_pkg::ACC_RST;
		end else if (reg_wr && reg_addr == crcpe_pkg::OFS_ACC_LOW) begin
			acc_reg[7:0] <= reg_wdata;
		end else if (reg_wr && reg_addr == crcpe_pkg::OFS_ACC_HIGH) begin
			acc_reg[15:8] <= reg_wdata;
		end else if (state_reg == crcpe_pkg::CRCPE_DATA) begin
			acc_reg <= crc_step(acc_reg, word_reg[bit_idx], poly, poly_len_reg,
				aug_reg);
		end
	end

	// Sequencer: one bit per clock, back to idle after the last data bit
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_reg <= crcpe_pkg::CRCPE_IDLE;
			cnt_reg <= '0;
			word_reg <= '0;
		end else if (!en_reg) begin
			state_reg <= crcpe_pkg::CRCPE_IDLE;
			cnt_reg <= '0;
		end else begin
			case (state_reg)
				crcpe_pkg::CRCPE_IDLE: begin
					if (pop) begin
						word_reg <= f_out_data;
						cnt_reg <= '0;
						state_reg <= crcpe_pkg::CRCPE_DATA;
					end
				end
				crcpe_pkg::CRCPE_DATA: begin
					if (last_bit) begin
						// Augmentation costs no extra cycles in the direct form
						cnt_reg <= '0;
						state_reg <= crcpe_pkg::CRCPE_IDLE;
					end else begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				default: begin
					state_reg <= crcpe_pkg::CRCPE_IDLE;
				end
			endcase
		end
	end

	// Read decode
	always_comb begin
		rdata_next = 8'h00;
		if (reg_addr == crcpe_pkg::OFS_CTRL) begin
			rdata_next[crcpe_pkg::CTRL_EN_BIT] = en_reg;
			rdata_next[crcpe_pkg::CTRL_GO_BIT] = go_reg;
			rdata_next[crcpe_pkg::CTRL_ORDER_BIT] = order_reg;
			rdata_next[crcpe_pkg::CTRL_AUG_BIT] = aug_reg;
			rdata_next[crcpe_pkg::CTRL_BUSY_BIT] = busy;
			rdata_next[crcpe_pkg::CTRL_FULL_BIT] = full;
		end else if (reg_addr == crcpe_pkg::OFS_LEN) begin
			rdata_next = {poly_len_reg, word_len_reg};
		end else if (reg_addr == crcpe_pkg::OFS_ACC_LOW) begin
			rdata_next = acc_reg[7:0];
		end else if (reg_addr == crcpe_pkg::OFS_ACC_HIGH) begin
			rdata_next = acc_reg[15:8];
		end else if (reg_addr == crcpe_pkg::OFS_TAPS_LOW) begin
			rdata_next = {taps_reg[7:1], 1'b1};
		end else if (reg_addr == crcpe_pkg::OFS_TAPS_HIGH) begin
			rdata_next = taps_reg[15:8];
		end else if (reg_addr == crcpe_pkg::OFS_DATA_HIGH) begin
			rdata_next = data_high_reg;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= reg_rd ? rdata_next : 8'h00;
		end
	end
	assign reg_rdata = rdata_reg;

	// Checks
	chk_taps_lsb_read: assert property (@(posedge ref_clk) disable iff (srst)
		reg_rd && reg_addr == crcpe_pkg::OFS_TAPS_LOW |=> reg_rdata[0])
		else $error("taps bit 0 did not read as one");

	chk_stop_no_run: assert property (@(posedge ref_clk) disable iff (srst)
		!run && state_reg == crcpe_pkg::CRCPE_IDLE |=> state_reg == crcpe_pkg::CRCPE_IDLE)
		else $error("engine started while not enabled");

	chk_pop_starts: assert property (@(posedge ref_clk) disable iff (srst)
		pop |=> state_reg == crcpe_pkg::CRCPE_DATA && cnt_reg == 5'h00)
		else $error("word taken without starting data shift");

	chk_busy_active: assert property (@(posedge ref_clk) disable iff (srst)
		state_reg != crcpe_pkg::CRCPE_IDLE |-> busy)
		else $error("busy low while shifting");

	chk_acc_masked: assert property (@(posedge ref_clk) disable iff (srst)
		state_reg == crcpe_pkg::CRCPE_DATA && !acc_wr
		&& !(reg_wr && reg_addr == crcpe_pkg::OFS_LEN)
		|=> (acc_reg & ~(16'hFFFF >> (4'hF - poly_len_reg))) == 16'h0000)
		else $error("accumulator bits above length after shift");

	chk_aug_entry: assert property (@(posedge ref_clk) disable iff (srst)
		state_reg == crcpe_pkg::CRCPE_DATA && aug_reg && !acc_wr
		&& acc_reg[poly_len_reg] == word_reg[bit_idx]
		|=> acc_reg == (($past(acc_reg) << 1) & (16'hFFFF >> (4'hF - $past(poly_len_reg)))))
		else $error("augmented shift fed back although data matched the top bit");

	chk_no_aug: assert property (@(posedge ref_clk) disable iff (srst)
		state_reg == crcpe_pkg::CRCPE_DATA && last_bit && !aug_reg
		|=> state_reg == crcpe_pkg::CRCPE_IDLE)
		else $error("zeros appended with augment clear");

	chk_low_latch: assert property (@(posedge ref_clk) disable iff (srst)
		sw_push && f_in_ready |=> f_out_valid)
		else $error("low byte write did not queue a word");

	chk_data_len: assert property (@(posedge ref_clk) disable iff (srst)
		pop && word_len_reg == 4'h7
		|=> (state_reg == crcpe_pkg::CRCPE_DATA || !en_reg)[*8] ##1
		(state_reg == crcpe_pkg::CRCPE_IDLE))
		else $error("eight-bit word not shifted in eight cycles");
endmodule

// File: tb/crcpe_scan_model.sv
// Memory scanner stand-in feeding words over valid and ready
`timescale 1ns/100ps
module crcpe_scan_model (
	input wire logic ref_clk,
	input wire logic scan_ready,
	output logic scan_valid,
	output logic [15:0] scan_data
);
	logic [15:0] last_word = 16'h5A5A;

	// Idle at time zero with a non-stale data pattern
	initial begin
		scan_valid = 1'b0;
		scan_data = 16'hA5A5;
	end

	// Offer one word after a gap and hold it until taken
	task automatic send(input logic [15:0] w, input int gap, output logic ok);
		logic hit;
		ok = 1'b0;
		if (gap > 0) begin
			scan_valid <= 1'b0;
			scan_data <= ~last_word;
			repeat (gap) @(posedge ref_clk);
		end
		scan_valid <= 1'b1;
		scan_data <= w;
		last_word = w;
		for (int n = 0; n < 500 && !ok; n++) begin
			@(negedge ref_clk);
			hit = (scan_ready === 1'b1);
			@(posedge ref_clk);
			ok = hit;
		end
	endtask

	// Withdraw the offer; released data no longer shows the word
	task automatic stop();
		scan_valid <= 1'b0;
		scan_data <= ~last_word;
	endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the CRC engine
`timescale 1ns/100ps
module tb_top;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic scan_valid, scan_ready, busy, full, ok;
	logic [15:0] scan_data, exp_acc, m_taps, v16, w;
	logic [7:0] rv;
	logic [3:0] m_poly_len, m_wlen;
	logic m_rev, m_aug;
	logic [7:0] doc_bytes [4] = '{8'h55, 8'h66, 8'h77, 8'h88};
	int fail_count = 0;
	int comparisons = 0;
	int i;

	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;

	crcpe_engine #(.FIFO_D(16)) i_crcpe_engine (.ref_clk(ref_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .scan_valid(scan_valid), .scan_data(scan_data),
		.scan_ready(scan_ready), .busy(busy), .full(full));
	crcpe_scan_model i_crcpe_scan_model (.ref_clk(ref_clk), .scan_ready(scan_ready),
		.scan_valid(scan_valid), .scan_data(scan_data));

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		if (fail_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Register write and read cycles
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask

	task automatic rd16(input logic [2:0] a, output logic [15:0] d);
		rd(a, d[7:0]);
		rd(a + 3'h1, d[15:8]);
	endtask

	// Reference remainder after one word
	function automatic logic [15:0] crc_word(input logic [15:0] acc, input logic [15:0] x);
		logic [15:0] mask, poly;
		logic b, fb;
		mask = 16'hFFFF >> (4'hF - m_poly_len);
		poly = (m_taps | 16'h0001) & mask;
		for (int k = 0; k <= m_wlen; k++) begin
			b = m_rev ? x[k] : x[m_wlen - k];
			fb = m_aug ? acc[m_poly_len] ^ b : acc[m_poly_len];
			acc = m_aug ? (acc << 1) & mask : ((acc << 1) | {15'h0000, b}) & mask;
			if (fb) begin
				acc = acc ^ poly;
			end
		end
		return acc;
	endfunction

	task automatic setup(input logic [7:0] c, input logic [7:0] len, input logic [15:0] t,
		input logic [15:0] seed);
		wr(crcpe_pkg::OFS_CTRL, 8'h00);
		wr(crcpe_pkg::OFS_LEN, len);
		wr(crcpe_pkg::OFS_TAPS_LOW, t[7:0]);
		wr(crcpe_pkg::OFS_TAPS_HIGH, t[15:8]);
		wr(crcpe_pkg::OFS_ACC_LOW, seed[7:0]);
		wr(crcpe_pkg::OFS_ACC_HIGH, seed[15:8]);
		wr(crcpe_pkg::OFS_CTRL, c);
		{m_poly_len, m_wlen} = len;
		m_taps = t;
		m_rev = c[2];
		m_aug = c[3];
		exp_acc = seed & (16'hFFFF >> (4'hF - m_poly_len));
	endtask

	// High byte first, low byte queues the word
	task automatic put(input logic [15:0] x);
		wr(crcpe_pkg::OFS_DATA_HIGH, x[15:8]);
		wr(crcpe_pkg::OFS_DATA_LOW, x[7:0]);
		exp_acc = crc_word(exp_acc, x);
	endtask

	task automatic feed_doc();
		for (int k = 0; k < 4; k++) begin
			put({8'hC3, doc_bytes[k]});
		end
	endtask

	task automatic done_chk(input string nm);
		logic [15:0] v;
		int n;
		n = 0;
		@(negedge ref_clk);
		while (busy !== 1'b0 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 3000) begin
			fail_count++;
			close_out();
		end
		rd16(crcpe_pkg::OFS_ACC_LOW, v);
		chk(nm, v, exp_acc);
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		for (i = 0; i < 8; i++) begin
			rd(i[2:0], rv);
			chk("reset_reg", {8'h00, rv}, (i == 4) ? 16'h0001 : 16'h0000);
		end
		wr(crcpe_pkg::OFS_CTRL, 8'h02);
		rd(crcpe_pkg::OFS_CTRL, rv);
		chk("go_without_en", {8'h00, rv}, 16'h0000);
		// Worked example, augmented, MSb first, junk above the word
		setup(8'h0B, 8'hF7, 16'h8004, 16'h0000);
		rd16(crcpe_pkg::OFS_TAPS_LOW, v16);
		chk("taps_read", v16, 16'h8005);
		feed_doc();
		chk("ref_value", exp_acc, 16'h32D6);
		done_chk("aug_msb");
		// Same value with zeros supplied as data
		setup(8'h03, 8'hF7, 16'h8004, 16'h0000);
		feed_doc();
		put(16'h0000);
		put(16'h0000);
		chk("ref_zeros", exp_acc, 16'h32D6);
		done_chk("user_zeros");
		setup(8'h0F, 8'hF7, 16'h8004, 16'h0000);
		feed_doc();
		chk("ref_lsb", exp_acc, 16'h6BA2);
		done_chk("lsb_first");
		// 12-bit words, 8-bit remainder, seeded
		setup(8'h03, 8'h7B, 16'h0006, 16'h00A5);
		rd16(crcpe_pkg::OFS_ACC_LOW, v16);
		chk("seed_read", v16, 16'h00A5);
		wr(crcpe_pkg::OFS_DATA_HIGH, 8'h12);
		repeat (3) @(negedge ref_clk);
		chk("high_only", {15'h0000, busy}, 16'h0000);
		put(16'hF123);
		put(16'h0ABC);
		done_chk("wide_word");
		// Fill the buffer while stopped, overflow, then drain
		setup(8'h01, 8'hF7, 16'h8004, 16'h0000);
		for (i = 0; i < 16; i++) begin
			put({8'h00, i[7:0]} ^ 16'h003C);
		end
		// Let the last push settle before looking
		@(negedge ref_clk);
		chk("full_pin", {15'h0000, full}, 16'h0001);
		wr(crcpe_pkg::OFS_DATA_HIGH, 8'h00);
		wr(crcpe_pkg::OFS_DATA_LOW, 8'hEE);
		rd(crcpe_pkg::OFS_CTRL, rv);
		chk("full_bit", {15'h0000, rv[7]}, 16'h0001);
		wr(crcpe_pkg::OFS_CTRL, 8'h03);
		done_chk("fifo_drain");
		chk("full_clear", {15'h0000, full}, 16'h0000);
		// Scanner words, back to back and with gaps
		setup(8'h03, 8'hFF, 16'h1021, 16'h0000);
		for (i = 0; i < 6; i++) begin
			w = 16'hB00D ^ {i[7:0], i[7:0]};
			i_crcpe_scan_model.send(w, i % 3, ok);
			chk("scan_taken", {15'h0000, ok}, 16'h0001);
			exp_acc = crc_word(exp_acc, w);
		end
		i_crcpe_scan_model.stop();
		done_chk("scanner");
		close_out();
	end
endmodule
